//--- hdl/cbr_bridge_ctrl.sv
// Contract
// - Bits 15 to 11 read zero.
// - Post writes only when bit 10 set.
// - Posting may cover burst writes only.
// - Bit 9 window 1 prefetchable, resets one.
// - Bit 8 window 0 prefetchable, resets one.
// - Bit 7 selects legacy interrupt routing.
// - Bit 6 drives card reset, resets one.
// - Host bus reset also resets card.
// - Bit 5 reports card master aborts.
// - Bit 4 reads zero.
// - Bit 3 forwards VGA addresses.
// - Bit 2 filters upper ISA block bytes.
// - Bit 1 forwards card system error.
// - Bit 0 reports card parity errors.
// - Bits 5,1,0 shared, written via function 0.
// - Subsystem words writable only when enabled.
// - Base is index port, next data.
// - Base bit 0 reads one.
// - One legacy base for both functions.
// - Write enable comes from system control.
module cbr_bridge_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic        cfg_func,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  input  wire logic        subsys_word_write_enable,
  input  wire logic        host_serr_enable,
  input  wire logic [1:0]  card_master_abort,
  input  wire logic [1:0]  card_parity_detect,
  input  wire logic [1:0]  card_system_error_n,
  input  wire logic        io_req,
  input  wire logic        io_socket,
  input  wire logic [31:0] io_addr,
  output logic      [1:0]  write_post_enable,
  output logic      [1:0]  window1_prefetchable,
  output logic      [1:0]  window0_prefetchable,
  output logic      [1:0]  func_irq_route_select,
  output logic      [1:0]  card_reset,
  output logic      [1:0]  vga_forward_enable,
  output logic      [1:0]  isa_range_filter_enable,
  output logic             master_abort_report_mode,
  output logic             card_syserr_forward_enable,
  output logic             card_parity_response_enable,
  output logic             host_serr_req,
  output logic      [1:0]  target_abort_req,
  output logic      [1:0]  card_parity_report,
  output logic             legacy_index_sel,
  output logic             legacy_data_sel,
  output logic             io_forward,
  output logic             vga_io_forward
);

  // Dword indices of the configuration registers.
  localparam logic [5:0] BC_DW   = cbr_pkg::BRIDGE_CTRL_OFS[7:2];
  localparam logic [5:0] SUB_DW  = cbr_pkg::SUBSYS_MAKER_OFS[7:2];
  localparam logic [5:0] BASE_DW = cbr_pkg::LEGACY_BASE_OFS[7:2];

  logic [15:0] local_q [2];   // Per-socket bridge control bits.
  logic [15:0] local_d [2];   // Next per-socket bits.
  logic [15:0] glob_q;        // Shared global bridge control bits.
  logic [15:0] glob_d;        // Next global bits.
  logic [15:0] maker_q [2];   // Subsystem maker word per function.
  logic [15:0] maker_d [2];   // Next maker words.
  logic [15:0] part_q  [2];   // Subsystem part word per function.
  logic [15:0] part_d  [2];   // Next part words.
  logic [31:0] base_q;        // Single legacy index port base.
  logic [31:0] base_d;        // Next legacy base.
  logic [31:0] rdata_q;       // Registered read data.
  logic [31:0] rdata_d;       // Next read data.
  logic        ack_q;         // Registered access acknowledge.
  logic        ack_d;         // Next acknowledge.
  logic [15:0] bc_view;       // Bridge control as seen by the function.
  logic [15:0] bc_wval;       // Bridge control after byte lane merge.
  logic [5:0]  dw;            // Dword index of the access.
  logic [1:0]  serr_sync;     // Synchronised card system error, active high.
  logic [1:0]  serr_sync_n;   // Synchroniser output, active low.
  logic        ev_serr_q;     // Host system error request.
  logic        ev_serr_d;
  logic [1:0]  ev_tabt_q;     // Target abort requests per socket.
  logic [1:0]  ev_tabt_d;
  logic [1:0]  ev_perr_q;     // Parity report per socket.
  logic [1:0]  ev_perr_d;
  logic        idx_q;         // Decoded index port select.
  logic        dat_q;         // Decoded data port select.
  logic        fwd_q;         // I/O cycle may be forwarded.
  logic        vga_q;         // VGA I/O cycle forwarded.
  logic        idx_hit;
  logic        dat_hit;
  logic        isa_blk;
  logic        vga_hit;

  // Card system error pins arrive asynchronously and idle high.
  cbr_sync #(.WIDTH(2)) u_serr_sync (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .ce          (ce),
    .async_in    (card_system_error_n),
    .reset_level (2'h3),
    .sync_out    (serr_sync_n)
  );

  assign serr_sync = ~serr_sync_n;

  // Decode uses the control bits of the socket that the cycle targets.
  cbr_io_decode u_io_decode (
    .io_addr     (io_addr),
    .legacy_base (base_q),
    .isa_filter  (local_q[io_socket][cbr_pkg::BC_ISA]),
    .vga_enable  (local_q[io_socket][cbr_pkg::BC_VGA]),
    .index_hit   (idx_hit),
    .data_hit    (dat_hit),
    .isa_blocked (isa_blk),
    .vga_forward (vga_hit)
  );

  // Configuration register next state, read data and write effects.
  always_comb begin
    dw = cfg_addr[7:2];
    local_d = local_q;
    glob_d  = glob_q;
    maker_d = maker_q;
    part_d  = part_q;
    base_d  = base_q;
    rdata_d = rdata_q;
    ack_d   = cfg_req;
    // Globals come from the shared copy.
    bc_view = ((local_q[cfg_func] & ~cbr_pkg::BC_GLOBAL) | glob_q) &
              cbr_pkg::BC_WRITABLE;
    bc_wval = bc_view;
    if (cfg_be[2]) begin
      bc_wval[7:0] = cfg_wdata[23:16];
    end
    if (cfg_be[3]) begin
      bc_wval[15:8] = cfg_wdata[31:24];
    end
    if (cfg_req && !cfg_we) begin
      // Unmapped dwords read zero.
      rdata_d = 32'h00000000;
      if (dw == BC_DW) begin
        rdata_d = {bc_view, 16'h0000};
      end else if (dw == SUB_DW) begin
        rdata_d = {part_q[cfg_func], maker_q[cfg_func]};
      end else if (dw == BASE_DW) begin
        rdata_d = base_q;
      end
    end
    if (cfg_req && cfg_we) begin
      if (dw == BC_DW) begin
        local_d[cfg_func] = bc_wval & cbr_pkg::BC_WRITABLE &
                            ~cbr_pkg::BC_GLOBAL;
        if (!cfg_func) begin
          glob_d = bc_wval & cbr_pkg::BC_GLOBAL;
        end
      end else if ((dw == SUB_DW) && subsys_word_write_enable) begin
        if (cfg_be[0]) begin
          maker_d[cfg_func][7:0] = cfg_wdata[7:0];
        end
        if (cfg_be[1]) begin
          maker_d[cfg_func][15:8] = cfg_wdata[15:8];
        end
        if (cfg_be[2]) begin
          part_d[cfg_func][7:0] = cfg_wdata[23:16];
        end
        if (cfg_be[3]) begin
          part_d[cfg_func][15:8] = cfg_wdata[31:24];
        end
      end else if (dw == BASE_DW) begin
        if (cfg_be[0]) begin
          base_d[7:0] = cfg_wdata[7:0];
        end
        if (cfg_be[1]) begin
          base_d[15:8] = cfg_wdata[15:8];
        end
        if (cfg_be[2]) begin
          base_d[23:16] = cfg_wdata[23:16];
        end
        if (cfg_be[3]) begin
          base_d[31:24] = cfg_wdata[31:24];
        end
        base_d[0] = 1'b1;
      end
    end
  end

  // Configuration registers; reset wins over the clock enable.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Host bus reset holds card reset.
      local_q <= '{cbr_pkg::BC_RESET, cbr_pkg::BC_RESET};
      glob_q  <= cbr_pkg::BC_RESET & cbr_pkg::BC_GLOBAL;
      maker_q <= '{cbr_pkg::SUBSYS_RESET, cbr_pkg::SUBSYS_RESET};
      part_q  <= '{cbr_pkg::SUBSYS_RESET, cbr_pkg::SUBSYS_RESET};
      base_q  <= cbr_pkg::LEGACY_BASE_RESET;
      rdata_q <= 32'h00000000;
      ack_q   <= 1'b0;
    end else if (ce) begin
      local_q <= local_d;
      glob_q  <= glob_d;
      maker_q <= maker_d;
      part_q  <= part_d;
      base_q  <= base_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  // Error events and I/O decode results, each registered once.
  always_comb begin
    ev_serr_d = (|serr_sync && glob_q[cbr_pkg::BC_SERR]) ||
                (host_serr_enable && glob_q[cbr_pkg::BC_MABT] &&
                 |card_master_abort);
    ev_tabt_d = card_master_abort & {2{glob_q[cbr_pkg::BC_MABT]}};
    ev_perr_d = card_parity_detect & {2{glob_q[cbr_pkg::BC_PERR]}};
  end

  // Event and decode registers; decode outputs hold zero when idle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ev_serr_q <= 1'b0;
      ev_tabt_q <= 2'h0;
      ev_perr_q <= 2'h0;
      idx_q     <= 1'b0;
      dat_q     <= 1'b0;
      fwd_q     <= 1'b0;
      vga_q     <= 1'b0;
    end else if (ce) begin
      ev_serr_q <= ev_serr_d;
      ev_tabt_q <= ev_tabt_d;
      ev_perr_q <= ev_perr_d;
      idx_q     <= io_req && idx_hit;
      dat_q     <= io_req && dat_hit;
      fwd_q     <= io_req && !isa_blk;
      vga_q     <= io_req && vga_hit;
    end
  end

  genvar gs;

  generate
    for (gs = 0; gs < 2; gs++) begin : g_sock
      // Posting scope left to the datapath.
      assign write_post_enable[gs]       = local_q[gs][cbr_pkg::BC_POST];
      assign window1_prefetchable[gs]    = local_q[gs][cbr_pkg::BC_PF1];
      assign window0_prefetchable[gs]    = local_q[gs][cbr_pkg::BC_PF0];
      assign func_irq_route_select[gs]   = local_q[gs][cbr_pkg::BC_ROUTE];
      assign card_reset[gs]              = local_q[gs][cbr_pkg::BC_CARD_RESET];
      assign vga_forward_enable[gs]      = local_q[gs][cbr_pkg::BC_VGA];
      assign isa_range_filter_enable[gs] = local_q[gs][cbr_pkg::BC_ISA];
    end
  endgenerate

  assign master_abort_report_mode    = glob_q[cbr_pkg::BC_MABT];
  assign card_syserr_forward_enable  = glob_q[cbr_pkg::BC_SERR];
  assign card_parity_response_enable = glob_q[cbr_pkg::BC_PERR];
  assign cfg_rdata          = rdata_q;
  assign cfg_ack            = ack_q;
  assign host_serr_req      = ev_serr_q;
  assign target_abort_req   = ev_tabt_q;
  assign card_parity_report = ev_perr_q;
  assign legacy_index_sel   = idx_q;
  assign legacy_data_sel    = dat_q;
  assign io_forward         = fwd_q;
  assign vga_io_forward     = vga_q;

  // Checks on the register file and event paths.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic rd_bc;
  logic wr_bc;
  assign rd_bc = ce && cfg_req && !cfg_we && (dw == BC_DW);
  assign wr_bc = ce && cfg_req && cfg_we && (dw == BC_DW);

  chk_rsvd_read_zero: assert property (
    rd_bc |=> (cfg_rdata[31:27] == 5'h00) && !cfg_rdata[20])
    else $error("reserved bridge control bits read nonzero");
  chk_post_per_func: assert property (
    wr_bc && cfg_func && cfg_be[3] |=>
    (write_post_enable[1] == $past(cfg_wdata[26])) && $stable(local_q[0]))
    else $error("posting enable not kept per function");
  chk_reset_values: assert property (
    $rose(rst_n) |-> (window1_prefetchable == 2'h3) &&
    (window0_prefetchable == 2'h3) && (card_reset == 2'h3))
    else $error("control bits wrong after reset");
  chk_bus_reset_card: assert property (
    @(posedge mclk) disable iff (1'b0) !rst_n |=> card_reset == 2'h3)
    else $error("card reset not held under bus reset");
  chk_global_func1: assert property (
    wr_bc && cfg_func |=> $stable(glob_q))
    else $error("function 1 changed a global bit");
  chk_global_func0: assert property (
    wr_bc && !cfg_func && cfg_be[2] |=>
    master_abort_report_mode == $past(cfg_wdata[21]))
    else $error("function 0 global write lost");
  chk_mabt_silent: assert property (
    ce && !master_abort_report_mode |=> target_abort_req == 2'h0)
    else $error("master abort reported while silent");
  chk_mabt_report: assert property (
    ce && master_abort_report_mode && card_master_abort[0] &&
    host_serr_enable |=> target_abort_req[0] ##0 host_serr_req)
    else $error("master abort not reported");
  chk_serr_ignored: assert property (
    ce && !card_syserr_forward_enable && !master_abort_report_mode
    |=> !host_serr_req)
    else $error("card system error forwarded while off");
  chk_serr_forward: assert property (
    ce && card_syserr_forward_enable && !card_system_error_n[0] ##1
    ce[*2] |=> host_serr_req)
    else $error("card system error not forwarded");
  chk_parity_gate: assert property (
    ce && !card_parity_response_enable |=> card_parity_report == 2'h0)
    else $error("parity reported while disabled");
  chk_subsys_locked: assert property (
    !subsys_word_write_enable |=>
    $stable({maker_q[0], maker_q[1], part_q[0], part_q[1]}))
    else $error("subsystem word changed while locked");
  chk_base_bit_one: assert property (
    ce && cfg_req && !cfg_we && (dw == BASE_DW) |=> cfg_rdata[0])
    else $error("legacy base bit 0 read zero");
  chk_index_decode: assert property (
    ce && io_req && (io_addr == {base_q[31:1], 1'b0}) |=>
    legacy_index_sel && !legacy_data_sel)
    else $error("index port not decoded");
  chk_isa_filter: assert property (
    ce && io_req && isa_range_filter_enable[io_socket] &&
    (io_addr[31:16] == 16'h0000) && (io_addr[9:8] != 2'h0) |=> !io_forward)
    else $error("filtered ISA cycle forwarded");
  chk_ack_timing: assert property (
    ce && cfg_req |=> cfg_ack)
    else $error("access not acknowledged");

  cov_global_write: cover property (wr_bc && !cfg_func);
  cov_mabt_report: cover property (|target_abort_req);
  cov_legacy_data: cover property (legacy_data_sel);

endmodule

//--- hdl/cbr_io_decode.sv
// Combinational I/O address decode for one socket's view of a cycle.
module cbr_io_decode (
  input  wire logic [31:0] io_addr,
  input  wire logic [31:0] legacy_base,
  input  wire logic        isa_filter,
  input  wire logic        vga_enable,
  output logic             index_hit,
  output logic             data_hit,
  output logic             isa_blocked,
  output logic             vga_forward
);

  logic in_isa;
  logic vga_range;

  // The base is word aligned, so bit 0 selects index or data port.
  always_comb begin
    index_hit = (io_addr[31:1] == legacy_base[31:1]) && !io_addr[0];
    data_hit  = (io_addr[31:1] == legacy_base[31:1]) && io_addr[0];
    in_isa    = (io_addr[31:16] == 16'h0000);
    // Upper 768 bytes of each 1K block.
    isa_blocked = isa_filter && in_isa && (io_addr[9:8] != 2'h0);
    vga_range = ((io_addr >= cbr_pkg::VGA_IO_A_LO) &&
                 (io_addr <= cbr_pkg::VGA_IO_A_HI)) ||
                ((io_addr >= cbr_pkg::VGA_IO_B_LO) &&
                 (io_addr <= cbr_pkg::VGA_IO_B_HI));
    vga_forward = vga_enable && vga_range;
  end

endmodule

//--- hdl/cbr_pkg.sv
package cbr_pkg;

  // Number of card sockets, one configuration function each.
  localparam int unsigned NUM_SOCKETS = 2;

  // Configuration space byte offsets of the registers.
  localparam logic [7:0] BRIDGE_CTRL_OFS  = 8'h3E;
  localparam logic [7:0] SUBSYS_MAKER_OFS = 8'h40;
  localparam logic [7:0] SUBSYS_PART_OFS  = 8'h42;
  localparam logic [7:0] LEGACY_BASE_OFS  = 8'h44;

  // Reset values.
  localparam logic [15:0] BC_RESET          = 16'h0340;
  localparam logic [15:0] SUBSYS_RESET      = 16'h0000;
  localparam logic [31:0] LEGACY_BASE_RESET = 32'h00000001;

  // Bridge control masks: bits that store a value, and the global ones.
  localparam logic [15:0] BC_WRITABLE = 16'h07EF;
  localparam logic [15:0] BC_GLOBAL   = 16'h0023;

  // Bridge control field positions.
  localparam int unsigned BC_POST  = 10;
  localparam int unsigned BC_PF1   = 9;
  localparam int unsigned BC_PF0   = 8;
  localparam int unsigned BC_ROUTE = 7;
  localparam int unsigned BC_CARD_RESET  = 6;
  localparam int unsigned BC_MABT  = 5;
  localparam int unsigned BC_VGA   = 3;
  localparam int unsigned BC_ISA   = 2;
  localparam int unsigned BC_SERR  = 1;
  localparam int unsigned BC_PERR  = 0;

  // Legacy VGA I/O ranges.
  localparam logic [31:0] VGA_IO_A_LO = 32'h000003B0;
  localparam logic [31:0] VGA_IO_A_HI = 32'h000003BB;
  localparam logic [31:0] VGA_IO_B_LO = 32'h000003C0;
  localparam logic [31:0] VGA_IO_B_HI = 32'h000003DF;

endpackage

//--- hdl/cbr_sync.sv
// Two-stage synchroniser for asynchronous pin levels, one chain per bit.
module cbr_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_level,
  output logic      [WIDTH-1:0] sync_out
);

  genvar gi;

  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      // The first stage is read only by the second stage.
      logic meta_q;
      logic meta_d;
      logic sync_q;
      logic sync_d;

      // Next values simply shift the chain.
      always_comb begin
        meta_d = async_in[gi];
        sync_d = meta_q;
      end

      // The reset value is a constant supplied by the instance.
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          meta_q <= reset_level[gi];
          sync_q <= reset_level[gi];
        end else if (ce) begin
          meta_q <= meta_d;
          sync_q <= sync_d;
        end
      end

      assign sync_out[gi] = sync_q;
    end
  endgenerate

endmodule

//--- test/cbr_card_model.sv
// Card socket side model: raises abort, parity and system error events.
module cbr_card_model (
  input  wire logic       mclk,
  output logic      [1:0] card_master_abort,
  output logic      [1:0] card_parity_detect,
  output logic      [1:0] card_system_error_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // The error pin has a pull-up, so it idles high between events.
  initial begin
    card_master_abort   = 2'h0;
    card_parity_detect  = 2'h0;
    card_system_error_n = 2'h3;
  end

  // Each event lasts one cycle, changed only on falling edges.
  task automatic ev(input int kind, input int s);
    @(negedge mclk);
    if (kind == 0) card_master_abort[s] = 1'b1;
    else if (kind == 1) card_parity_detect[s] = 1'b1;
    else card_system_error_n[s] = 1'b0;
    @(negedge mclk);
    card_master_abort   = 2'h0;
    card_parity_detect  = 2'h0;
    card_system_error_n = 2'h3;
  endtask
endmodule

//--- test/tb_cardbus_bridge_control_regs.sv
// Self-checking bench for the bridge control register bank.
module tb_cardbus_bridge_control_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus and observed signals of the design.
  logic        mclk, rst_n, ce, cfg_req, cfg_we, cfg_func, cfg_ack;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, io_addr, rd;
  logic        sub_we, serr_en, io_req, io_socket, host_serr_req;
  logic [1:0]  card_master_abort, card_parity_detect, card_system_error_n;
  logic [1:0]  post_en, pf1, pf0, route, card_reset, vga_en, isa_en;
  logic [1:0]  target_abort_req, card_parity_report;
  logic        mabt, serr_fwd, perr_en, idx_sel, dat_sel, io_fwd, vga_fwd;
  int          fail_count, total_checks;

  cbr_bridge_ctrl dut_u (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .subsys_word_write_enable(sub_we),
    .host_serr_enable(serr_en), .card_master_abort(card_master_abort),
    .card_parity_detect(card_parity_detect),
    .card_system_error_n(card_system_error_n), .io_req(io_req),
    .io_socket(io_socket), .io_addr(io_addr), .write_post_enable(post_en),
    .window1_prefetchable(pf1), .window0_prefetchable(pf0),
    .func_irq_route_select(route), .card_reset(card_reset),
    .vga_forward_enable(vga_en), .isa_range_filter_enable(isa_en),
    .master_abort_report_mode(mabt), .card_syserr_forward_enable(serr_fwd),
    .card_parity_response_enable(perr_en), .host_serr_req(host_serr_req),
    .target_abort_req(target_abort_req),
    .card_parity_report(card_parity_report), .legacy_index_sel(idx_sel),
    .legacy_data_sel(dat_sel), .io_forward(io_fwd),
    .vga_io_forward(vga_fwd));

  cbr_card_model card_u (
    .mclk(mclk), .card_master_abort(card_master_abort),
    .card_parity_detect(card_parity_detect),
    .card_system_error_n(card_system_error_n));

  // Free-running 125 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One configuration access; the answer is judged one cycle later.
  task automatic cfg(input logic we, input logic f, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] wd);
    @(negedge mclk);
    {cfg_req, cfg_we, cfg_func, cfg_addr} = {1'b1, we, f, a};
    {cfg_be, cfg_wdata} = {be, wd};
    @(negedge mclk);
    cfg_req = 1'b0;
    chk(cfg_ack, 1);
    rd = cfg_rdata;
  endtask

  // One I/O decode request; the decode is visible one cycle later.
  task automatic io(input logic s, input logic [31:0] a);
    @(negedge mclk);
    {io_req, io_socket, io_addr} = {1'b1, s, a};
    @(negedge mclk);
    io_req = 1'b0;
  endtask

  // Reset values of both bridge controls, the function 1 subsystem words, the base and the card reset outputs.
  task automatic t_reset;
    cfg(0, 0, 8'h3C, 4'hF, 0);
    chk(rd, 32'h03400000);
    cfg(0, 1, 8'h3C, 4'hF, 0);
    chk(rd, 32'h03400000);
    cfg(0, 1, 8'h40, 4'hF, 0);
    chk(rd, 0);
    cfg(0, 0, 8'h44, 4'hF, 0);
    chk(rd, 32'h00000001);
    chk({pf1, pf0, card_reset}, 6'h3F);
  endtask

  // Reserved bits, per-socket bits and function 1 global writes.
  task automatic t_bridge;
    cfg(1, 0, 8'h3C, 4'hC, 32'hFFFF0000);
    cfg(0, 0, 8'h3C, 4'hF, 0);
    chk(rd, 32'h07EF0000);
    chk({post_en, route, vga_en, isa_en}, 8'h55);
    chk({mabt, serr_fwd, perr_en}, 3'h7);
    cfg(1, 1, 8'h3C, 4'hC, 32'h00000000);
    cfg(0, 1, 8'h3C, 4'hF, 0);
    chk(rd, 32'h00230000);
    chk({pf1, pf0, card_reset}, 6'h15);
    cfg(0, 0, 8'h3C, 4'hF, 0);
    chk(rd, 32'h07EF0000);
  endtask

  // Subsystem words only take writes while the enable is high.
  task automatic t_subsys;
    cfg(1, 0, 8'h40, 4'hF, 32'h12345678);
    cfg(0, 0, 8'h40, 4'hF, 0);
    chk(rd, 0);
    sub_we = 1'b1;
    cfg(1, 0, 8'h40, 4'hF, 32'h12345678);
    sub_we = 1'b0;
    cfg(0, 0, 8'h40, 4'hF, 0);
    chk(rd, 32'h12345678);
  endtask

  // Shared base register and index/data port decode.
  task automatic t_base;
    cfg(1, 1, 8'h44, 4'hF, 32'hFFFF0010);
    cfg(0, 0, 8'h44, 4'hF, 0);
    chk(rd, 32'hFFFF0011);
    io(1, 32'hFFFF0010);
    chk({idx_sel, dat_sel}, 2'h2);
    io(0, 32'hFFFF0011);
    chk({idx_sel, dat_sel}, 2'h1);
  endtask

  // ISA range filter per socket and VGA forwarding.
  task automatic t_isa;
    io(0, 32'h00000100);
    chk(io_fwd, 0);
    io(0, 32'h000004FF);
    chk(io_fwd, 1);
    io(1, 32'h00000100);
    chk(io_fwd, 1);
    io(0, 32'h00010100);
    chk(io_fwd, 1);
    io(0, 32'h000003C0);
    chk(vga_fwd, 1);
    io(1, 32'h000003C0);
    chk(vga_fwd, 0);
  endtask

  // Card events; on selects whether the global enables are set.
  task automatic t_events(input logic on);
    card_u.ev(0, 0);
    chk({target_abort_req, host_serr_req}, {1'b0, on, on});
    card_u.ev(1, 1);
    chk(card_parity_report, {on, 1'b0});
    card_u.ev(2, 0);
    // The pin crosses two synchroniser stages before the event register,
    // so the request shows three edges after the pin went low.
    repeat (2) @(negedge mclk);
    chk(host_serr_req, on);
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    {rst_n, ce, cfg_req, cfg_we, cfg_func, cfg_addr, cfg_be} = 0;
    {cfg_wdata, sub_we, io_req, io_socket, io_addr} = 0;
    fail_count = 0;
    total_checks = 0;
    serr_en = 1'b1;
    ce = 1'b1;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    t_reset;
    t_bridge;
    t_subsys;
    t_base;
    t_isa;
    t_events(1'b1);
    cfg(1, 0, 8'h3C, 4'hC, 32'h00000000);
    t_events(1'b0);
    // A second bus reset must put both cards back into reset.
    @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    chk(card_reset, 2'h3);
    rst_n = 1'b1;
    report_and_stop;
  end

  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
endmodule
